// >>> rtl/sie_defines.svh
`ifndef SIE_DEFINES_SVH
`define SIE_DEFINES_SVH

// register byte offsets
`define SIE_OFF_IE_CLR   6'h00
`define SIE_OFF_IE_SET   6'h04
`define SIE_OFF_STATUS   6'h08
// number of interrupt sources
`define SIE_NSRC         12
// reset values
`define SIE_IE_RST       12'h000
`define SIE_STAT_RST     12'h000
`define SIE_DAT_RST      32'h0000_0000
// clear register bit that sets its enable instead
`define SIE_CLR_SETS     12'h002
// source bit positions
`define SIE_B_XTAL_MAIN  0
`define SIE_B_XTAL32K    1
`define SIE_B_SLOW_RC    2
`define SIE_B_FAST_RC    3
`define SIE_B_FLL_RDY    4
`define SIE_B_FLL_OOB    5
`define SIE_B_FLL_FINE   6
`define SIE_B_FLL_COARSE 7
`define SIE_B_FLL_REFSTP 8
`define SIE_B_BO_RDY     9
`define SIE_B_BO_DET     10
`define SIE_B_BO_SYNC    11

`endif

// >>> rtl/sie_irq_enable.sv
`include "sie_defines.svh"

// What this block does
// - writing zero to a clear register bit leaves that enable unchanged
// - writing one to bit 11 clears the brown-out sync-ready enable
// - writing one to bit 10 clears the brown-out detection enable
// - writing one to bit 9 clears the brown-out ready enable
// - writing one to bit 8 clears the loop reference-stopped enable
// - writing one to bit 7 clears the loop coarse-lock enable
// - writing one to bit 6 clears the loop fine-lock enable
// - writing one to bit 5 clears the loop out-of-bounds enable
// - writing one to bit 4 clears the loop ready enable
// - writing one to bit 3 clears the 8 MHz RC ready enable
// - writing one to bit 2 clears the 32 kHz RC ready enable
// - writing one to bit 1 of the clear register sets the crystal ready enable
// - an enabled source with its flag set raises a request; disabled raises none
// - the enable clear register sits at offset zero
// - enables reset to zero; write protection blocks enable register writes
// - the set register sets enables on ones and ignores zeros
module sie_irq_enable
  import sie_pkg::*;
#(
  parameter int NSRC = `SIE_NSRC
) (
  // clock, reset, enable
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            ce_i,
  // wishbone slave
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [5:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  // write protection and source flags
  input  wire logic            wprot_i,
  input  wire logic [NSRC-1:0] flag_i,
  // interrupt requests
  output logic      [NSRC-1:0] src_req_o,
  output logic                 irq_o
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic sie_reg_e reg_of(input logic [5:0] adr);
    case (adr)
      `SIE_OFF_IE_CLR: reg_of = SIE_R_IE_CLR;
      `SIE_OFF_IE_SET: reg_of = SIE_R_IE_SET;
      `SIE_OFF_STATUS: reg_of = SIE_R_STATUS;
      default:         reg_of = SIE_R_NONE;
    endcase
  endfunction : reg_of

  logic [NSRC-1:0] ie_reg;
  logic [NSRC-1:0] ie_next;
  logic [NSRC-1:0] stat_reg;
  logic [NSRC-1:0] stat_next;
  logic [31:0]     rd_next;
  sie_acc_s        acc;
  sie_reg_e        acc_reg;
  logic [NSRC-1:0] wmask;

  // ----------------------------------------
  // bus access capture
  // ----------------------------------------
  // the write lands at the edge where the master sees ack high
  always_comb begin
    acc.wr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    acc.rd    = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    acc.adr   = wb_adr_i;
    acc.dat   = wb_dat_i;
    acc.bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  end

  assign acc_reg = reg_of(acc.adr);
  assign wmask   = acc.dat[NSRC-1:0] & acc.bmask[NSRC-1:0];

  // ----------------------------------------
  // wishbone handshake
  // ----------------------------------------
  // one ack per request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // ----------------------------------------
  // interrupt enables
  // ----------------------------------------
  always_comb begin
    ie_next = ie_reg;
    if (acc.wr && !wprot_i) begin
      case (acc_reg)
        SIE_R_IE_CLR: begin
          // zeros keep, ones clear, one odd bit sets
          ie_next = (ie_reg & ~(wmask & ~`SIE_CLR_SETS))
                  | (wmask & `SIE_CLR_SETS);
        end
        SIE_R_IE_SET: begin
          ie_next = ie_reg | wmask;
        end
        default: begin
          ie_next = ie_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ie_reg <= `SIE_IE_RST;
    end else if (ce_i) begin
      ie_reg <= ie_next;
    end
  end

  // ----------------------------------------
  // sticky source status
  // ----------------------------------------
  // a flag in the clearing cycle wins over the clear
  always_comb begin
    stat_next = stat_reg;
    if (acc.wr && acc_reg == SIE_R_STATUS) begin
      stat_next = stat_reg & ~wmask;
    end
    stat_next = stat_next | flag_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= `SIE_STAT_RST;
    end else if (ce_i) begin
      stat_reg <= stat_next;
    end
  end

  // ----------------------------------------
  // request outputs
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_req
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          src_req_o[g] <= 1'b0;
        end else if (ce_i) begin
          src_req_o[g] <= stat_next[g] && ie_next[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(stat_next & ie_next);
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    rd_next = `SIE_DAT_RST;
    case (acc_reg)
      SIE_R_IE_CLR: rd_next[NSRC-1:0] = ie_reg;
      SIE_R_IE_SET: rd_next[NSRC-1:0] = ie_reg;
      SIE_R_STATUS: rd_next[NSRC-1:0] = stat_reg;
      default:      rd_next = `SIE_DAT_RST;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `SIE_DAT_RST;
    end else if (ce_i) begin
      if (acc.rd) begin
        wb_dat_o <= rd_next;
      end else begin
        wb_dat_o <= `SIE_DAT_RST;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_clr_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc.wr && acc_reg == SIE_R_IE_CLR && !wprot_i
    |=> (ie_reg & ~$past(wmask)) == ($past(ie_reg) & ~$past(wmask)))
    else $error("clear register zero changed an enable");

  chk_clr_bit_11: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc.wr && acc_reg == SIE_R_IE_CLR && !wprot_i
    && wmask[`SIE_B_BO_SYNC] |=> !ie_reg[`SIE_B_BO_SYNC])
    else $error("sync ready enable not cleared");

  chk_clr_bit_10: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc.wr && acc_reg == SIE_R_IE_CLR && !wprot_i
    && wmask[`SIE_B_BO_DET] |=> !ie_reg[`SIE_B_BO_DET] && !src_req_o[`SIE_B_BO_DET])
    else $error("detection enable not cleared");

  chk_clr_low_bits: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && acc.wr && acc_reg == SIE_R_IE_CLR && !wprot_i
    |=> (ie_reg[`SIE_B_BO_RDY:`SIE_B_SLOW_RC]
         & $past(wmask[`SIE_B_BO_RDY:`SIE_B_SLOW_RC])) == 8'h00)
    else $error("clear register one left an enable set");

  chk_clr_sets_xtal: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc.wr && acc_reg == SIE_R_IE_CLR && !wprot_i
    && wmask[`SIE_B_XTAL32K] |=> ie_reg[`SIE_B_XTAL32K])
    else $error("crystal ready enable not set");

  chk_req_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !acc.wr |=> irq_o == |(stat_reg & ie_reg))
    else $error("interrupt output disagrees with status and enables");

  chk_set_reg: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc.wr && acc_reg == SIE_R_IE_SET && !wprot_i
    |=> ie_reg == ($past(ie_reg) | $past(wmask)))
    else $error("set register write wrong");

  chk_wprot_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc.wr && wprot_i && acc_reg != SIE_R_STATUS |=> $stable(ie_reg))
    else $error("protected write changed enables");

  chk_read_enables: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc.rd && wb_adr_i == `SIE_OFF_IE_CLR
    |=> wb_ack_o && wb_dat_o[NSRC-1:0] == $past(ie_reg))
    else $error("clear register read not the enables");

  chk_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  chk_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");

  chk_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == `SIE_DAT_RST)
    else $error("read data outside the ack cycle");

  chk_read_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc.rd && wb_adr_i == `SIE_OFF_IE_SET
    |=> wb_ack_o && wb_dat_o[NSRC-1:0] == $past(ie_reg))
    else $error("set register read not the enables");

  chk_clr_bit_8: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc.wr && acc_reg == SIE_R_IE_CLR && !wprot_i
    && wmask[`SIE_B_FLL_REFSTP] |=> !ie_reg[`SIE_B_FLL_REFSTP])
    else $error("reference stopped enable not cleared");

  chk_clr_bit_0: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc.wr && acc_reg == SIE_R_IE_CLR && !wprot_i
    && wmask[`SIE_B_XTAL_MAIN] |=> !ie_reg[`SIE_B_XTAL_MAIN])
    else $error("main crystal enable not cleared");

  chk_set_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc.wr && acc_reg == SIE_R_IE_SET && !wprot_i
    |=> (ie_reg & ~$past(wmask)) == ($past(ie_reg) & ~$past(wmask)))
    else $error("set register zero changed an enable");

  chk_stat_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc.wr && acc_reg == SIE_R_STATUS
    |=> (stat_reg & $past(wmask & ~flag_i)) == {NSRC{1'b0}})
    else $error("status bit survived its clear");

  chk_flag_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && |flag_i
    |=> (stat_reg & $past(flag_i)) == $past(flag_i))
    else $error("flag lost against a status clear");

  chk_flag_raises: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !acc.wr && |(flag_i & ie_reg)
    |=> irq_o && ((src_req_o & $past(flag_i & ie_reg)) == $past(flag_i & ie_reg)))
    else $error("enabled flag raised no request");

  chk_disabled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i
    |=> (src_req_o & ~ie_reg) == {NSRC{1'b0}})
    else $error("request from a disabled source");

  chk_irq_is_or: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |src_req_o)
    else $error("interrupt output disagrees with the requests");

  chk_reset_clears: assert property (@(posedge clk_i)
    rst_i
    |=> ie_reg == `SIE_IE_RST && stat_reg == `SIE_STAT_RST && !irq_o && !wb_ack_o)
    else $error("reset left state behind");

  chk_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i
    |=> $stable(ie_reg) && $stable(stat_reg) && $stable(wb_ack_o) && $stable(irq_o))
    else $error("state moved with the clock enable low");

endmodule : sie_irq_enable

// >>> rtl/sie_pkg.sv
package sie_pkg;

  // register targeted by a bus access
  typedef enum {
    SIE_R_IE_CLR,
    SIE_R_IE_SET,
    SIE_R_STATUS,
    SIE_R_NONE
  } sie_reg_e;

  // one accepted bus access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  adr;
    logic [31:0] bmask;
    logic [31:0] dat;
  } sie_acc_s;

endpackage : sie_pkg

// >>> testbench/sie_irq_enable_tb_top.sv
module sie_irq_enable_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // signals and reference state
  // ------------------------------------------------------------
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        ce_i    = 1'b1;
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  logic        wb_we   = 1'b0;
  logic [5:0]  wb_adr  = 6'h00;
  logic [3:0]  wb_sel  = 4'h0;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        wprot   = 1'b0;
  logic [11:0] flag    = 12'h000;
  logic [11:0] src_req;
  logic        irq;
  logic [11:0] ie_m    = 12'h000;
  logic [11:0] st_m    = 12'h000;
  logic [31:0] rd;
  int          seed    = 32'hFEAB1DC2;
  int          n_mismatch = 0;
  int          n_checks   = 0;
  int          k;

  always #25 clk_i = ~clk_i;

  sie_irq_enable #(.NSRC(12)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .wprot_i(wprot), .flag_i(flag),
    .src_req_o(src_req), .irq_o(irq));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic test_done;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one classic cycle; reference state follows at the ack edge
  task automatic bus(input logic we, input logic [5:0] adr, input logic [3:0] sel,
                     input logic [31:0] d);
    logic [11:0] m;
    int          i;
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_sel  <= sel;
    wb_wdat <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack !== 1'b1 && i < 20);
    if (wb_ack !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
    rd = wb_rdat;
    m  = d[11:0] & {{4{sel[1]}}, {8{sel[0]}}};
    if (we && !wprot && adr == 6'h00) begin
      ie_m = (ie_m & ~(m & ~12'h002)) | (m & 12'h002);
    end
    if (we && !wprot && adr == 6'h04) begin
      ie_m = ie_m | m;
    end
    if (we && adr == 6'h08) begin
      st_m = st_m & ~m;
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic rdchk;
    bus(1'b0, 6'h00, 4'hF, 32'h0);
    chk("ie_clr", {20'h0, ie_m}, rd);
    bus(1'b0, 6'h04, 4'hF, 32'h0);
    chk("ie_set", {20'h0, ie_m}, rd);
    bus(1'b0, 6'h08, 4'hF, 32'h0);
    chk("status", {20'h0, st_m}, rd);
  endtask : rdchk

  // one-cycle flag burst, frozen when the clock enable is low
  task automatic pulse(input logic [11:0] f, input logic c);
    flag <= f;
    ce_i <= c;
    @(posedge clk_i);
    flag <= 12'h000;
    ce_i <= 1'b1;
    if (c) begin
      st_m = st_m | f;
    end
    repeat (3) @(posedge clk_i);
    chk("src_req", {20'h0, st_m & ie_m}, {20'h0, src_req});
    chk("irq", {31'h0, |(st_m & ie_m)}, {31'h0, irq});
  endtask : pulse

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk();
    bus(1'b0, 6'h0C, 4'hF, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (k = 0; k < 12; k++) begin
      bus(1'b1, 6'h04, 4'hF, 32'hFFFF_FFFF);
      pulse(12'hFFF, 1'b1);
      bus(1'b1, 6'h00, 4'hF, 32'h1 << k);
      rdchk();
      pulse(12'h000, 1'b1);
      bus(1'b1, 6'h08, 4'hF, 32'h0000_0FFF);
    end
    for (k = 0; k < 60; k++) begin
      wprot <= ($random(seed) % 4) == 0;
      bus(1'b1, 6'(($random(seed) & 3) * 4), 4'($random(seed)), $random(seed));
      wprot <= 1'b0;
      pulse(12'($random(seed)), 1'($random(seed)));
      rdchk();
    end
    bus(1'b1, 6'h04, 4'hF, 32'h0000_0FFF);
    pulse(12'hFFF, 1'b1);
    // flag held through a status clear: the set wins
    flag <= 12'h010;
    bus(1'b1, 6'h08, 4'hF, 32'h0000_0FFF);
    flag <= 12'h000;
    st_m = 12'h010;
    rdchk();
    pulse(12'h000, 1'b1);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    ie_m = 12'h000;
    st_m = 12'h000;
    @(posedge clk_i);
    rdchk();
    pulse(12'h000, 1'b1);
    // bit 1 of the clear register sets a cleared enable
    bus(1'b1, 6'h00, 4'h1, 32'h0000_0002);
    rdchk();
    test_done();
  end
endmodule : sie_irq_enable_tb_top
